// *** hdl/rpf_pkg.sv ***
package rpf_pkg;

    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_NS         = 20;
    localparam int STAB_NS        = 65_500_000;
    localparam int STAB_EXTRA_CYC = 7;
    localparam int STAB_CYC       = (STAB_NS + CLK_NS - 1) / CLK_NS + STAB_EXTRA_CYC;
    localparam int PIN_LOW_CYC    = 8;
    localparam int PF_NS          = 100;
    localparam int PF_CYC         = (PF_NS + CLK_NS - 1) / CLK_NS;
    localparam int XOUT_DIV       = 4;

    // ------------------------------------------------------------
    // reset vector
    // ------------------------------------------------------------
    localparam logic [15:0] VEC_LO_ADDR = 16'hfffe;
    localparam logic [15:0] VEC_HI_ADDR = 16'hffff;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_STATUS = 8'h04;
    localparam logic [7:0] ADDR_MASK   = 8'h08;
    localparam logic [7:0] ADDR_PAGE   = 8'h0c;
    localparam logic [7:0] ADDR_CFG    = 8'h10;
    localparam logic [7:0] ADDR_INFO   = 8'h14;

    // ------------------------------------------------------------
    // fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_W        = 5;
    localparam int CTRL_SF_EN    = 0;
    localparam int CTRL_SF_ACT   = 1;
    localparam int CTRL_WDT_EN   = 2;
    localparam int CTRL_PCLK_EN  = 3;
    localparam int CTRL_CLK_ALT  = 4;
    localparam logic [4:0] CTRL_RST = 5'h00;

    localparam int ST_W     = 5;
    localparam int ST_POR   = 0;
    localparam int ST_PIN   = 1;
    localparam int ST_WDT   = 2;
    localparam int ST_SF    = 3;
    localparam int ST_AFAIL = 4;
    localparam logic [4:0] STATUS_RST = 5'h01;
    localparam logic [4:0] MASK_RST   = 5'h00;

    localparam int PAGE_W    = 8;
    localparam int PAGE_FLAG = 8;
    localparam logic [8:0] PAGE_RST = 9'h000;

    localparam int CFG_W        = 6;
    localparam int CFG_AS_PORT  = 0;
    localparam int CFG_PORT_EN  = 1;
    localparam int CFG_NOISE    = 2;
    localparam int CFG_IOSC_A   = 3;
    localparam int CFG_IOSC_B   = 4;
    localparam int CFG_AFAIL_EN = 5;
    localparam logic [5:0] CFG_RST = 6'h24;

    localparam int INFO_RUN  = 0;
    localparam int INFO_FRZ  = 1;
    localparam int INFO_PORT = 2;

endpackage

// *** hdl/rpf_reset_ctrl.sv ***
// Functional notes
// [R1] power-on, pin, watchdog, supply-fail and fetch-fail all merge into one reset
// [R2] reset held while supply indication reports a low supply
// [R3] outside party holds the reset pin low for at least 8 clocks
// [R4] release waits 65.5 ms plus 7 clocks before execution starts
// [R5] program counter loaded from vector at fffe/ffff, then execution starts
// [R6] reset clears page register and flag, main clock, peripherals/watchdog/detector off
// [R7] no reset touches ram contents
// [R8] fetch from an invalid code region or ram region raises reset
// [R9] supply-fail detector enabled by a control bit
// [R10] supply low for 100 ns resets or freezes, chosen by a mode bit
// [R11] two option bits turn the reset pin into a plain input
// [R12] option bit enables the oscillator noise guard
// [R13] option area reachable only in flash program or verify mode
// [R14] internal oscillator option drives crystal output with clock divided by 4
// [R15] internal reset held continuously until stabilisation count completes
`timescale 1ns/100ps
module rpf_reset_ctrl
    import rpf_pkg::*;
#(
    parameter int          STAB_CYCLES = rpf_pkg::STAB_CYC,
    parameter logic [15:0] CODE_LO     = 16'hc000,
    parameter logic [15:0] RAM_HI      = 16'h01ff
) (
    // clock and power-on reset
    input  wire logic        core_clk_i,
    input  wire logic        rst_n_i,
    // apb slave
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [7:0]  paddr_i,
    input  wire logic [31:0] pwdata_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    output logic             irq_o,
    // pins and analog indications
    input  wire logic        reset_pin_n_i,
    input  wire logic        supply_ok_i,
    input  wire logic        supply_low_i,
    input  wire logic        flash_prog_mode_i,
    output logic             port_in_o,
    output logic             xout_o,
    // cpu side
    input  wire logic        wdt_timeout_i,
    input  wire logic        fetch_valid_i,
    input  wire logic [15:0] fetch_addr_i,
    output logic             vec_rd_o,
    output logic      [15:0] vec_addr_o,
    input  wire logic [7:0]  vec_data_i,
    output logic      [15:0] pc_o,
    output logic             pc_load_o,
    output logic             cpu_rst_o,
    output logic             freeze_o,
    // system controls
    output logic      [7:0]  ram_page_o,
    output logic             page_flag_o,
    output logic             clk_alt_sel_o,
    output logic             periph_clk_en_o,
    output logic             wdt_en_o,
    output logic             supply_fail_en_o,
    output logic             osc_noise_guard_o,
    output logic             int_osc_sel_o
);
    import rpf_pkg::*;

    if (STAB_CYCLES < 1) begin : g_stab_chk
        $error("rpf_reset_ctrl: STAB_CYCLES must be at least 1");
    end

    typedef enum logic [2:0] {
        ST_STRETCH,
        ST_VEC_LO,
        ST_VEC_HI,
        ST_LOAD,
        ST_RUN
    } rpf_state_t;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    rpf_state_t        state_q;
    logic [CTRL_W-1:0] ctrl_q;
    logic [ST_W-1:0]   status_q;
    logic [ST_W-1:0]   mask_q;
    logic [8:0]        page_q;
    logic [CFG_W-1:0]  cfg_q;
    logic [2:0]        pin_s;
    logic              pin_n_s;
    logic              supply_ok_s;
    logic              supply_low_s;
    logic [3:0]        pin_cnt_q;
    logic              pin_rst_q;
    logic [3:0]        pf_cnt_q;
    logic              pf_trip_q;
    logic              afail_q;
    logic              stab_done;
    logic              src;
    logic              port_mode;
    logic              pin_low_x;
    logic              pf_low_x;
    logic              fetch_bad;
    logic              apb_setup;
    logic              apb_wr;
    logic              cfg_ok;
    logic [31:0]       rdata_d;
    logic              rerr_d;
    logic [ST_W-1:0]   st_set;
    logic [ST_W-1:0]   st_clr;
    logic [1:0]        xdiv_q;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    rpf_sync2 #(
        .W       (3),
        .RST_VAL (3'h1)
    ) u_sync (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .async_i    ({supply_low_i, supply_ok_i, reset_pin_n_i}),
        .sync_o     (pin_s)
    );

    assign pin_n_s      = pin_s[0];
    assign supply_ok_s  = pin_s[1];
    assign supply_low_s = pin_s[2];

    // ------------------------------------------------------------
    // reset sources
    // ------------------------------------------------------------
    assign port_mode = cfg_q[CFG_AS_PORT] & cfg_q[CFG_PORT_EN]; // [R11]
    assign pin_low_x = !pin_n_s && !port_mode;

    // short glitches on the pin are not a reset
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !pin_low_x) begin
            pin_cnt_q <= 4'h0;
            pin_rst_q <= 1'b0;
        end else begin
            if (pin_cnt_q != 4'(PIN_LOW_CYC)) begin
                pin_cnt_q <= pin_cnt_q + 4'h1;
            end
            if (pin_cnt_q == 4'(PIN_LOW_CYC - 1)) begin
                pin_rst_q <= 1'b1; // [R3]
            end
        end
    end

    assign pf_low_x = supply_low_s && ctrl_q[CTRL_SF_EN]; // [R9]

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !pf_low_x) begin
            pf_cnt_q  <= 4'h0;
            pf_trip_q <= 1'b0;
        end else begin
            if (pf_cnt_q != 4'(PF_CYC)) begin
                pf_cnt_q <= pf_cnt_q + 4'h1;
            end
            if (pf_cnt_q == 4'(PF_CYC - 1)) begin
                pf_trip_q <= 1'b1; // [R10]
            end
        end
    end

    // freeze lasts while the low supply persists
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            freeze_o <= 1'b0;
        end else begin
            freeze_o <= pf_trip_q && ctrl_q[CTRL_SF_ACT]; // [R10]
        end
    end

    assign fetch_bad = fetch_valid_i && (fetch_addr_i < CODE_LO || fetch_addr_i <= RAM_HI);

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            afail_q <= 1'b0;
        end else begin
            afail_q <= fetch_bad && cfg_q[CFG_AFAIL_EN] && state_q == ST_RUN; // [R8]
        end
    end

    assign src = !supply_ok_s // [R2]
               | pin_rst_q
               | wdt_timeout_i
               | (pf_trip_q & !ctrl_q[CTRL_SF_ACT])
               | afail_q; // [R1]

    rpf_stretch #(
        .LEN (STAB_CYCLES)
    ) u_stab (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .restart_i  (src),
        .done_o     (stab_done)
    );

    // ------------------------------------------------------------
    // release sequence
    // ------------------------------------------------------------
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || src) begin
            state_q    <= ST_STRETCH;
            cpu_rst_o  <= 1'b1; // [R15]
            vec_rd_o   <= 1'b0;
            vec_addr_o <= VEC_LO_ADDR;
            pc_load_o  <= 1'b0;
            if (!rst_n_i) begin
                pc_o <= 16'h0000;
            end
        end else begin
            case (state_q)
                ST_STRETCH: begin
                    if (stab_done) begin
                        state_q    <= ST_VEC_LO; // [R4]
                        vec_rd_o   <= 1'b1;
                        vec_addr_o <= VEC_LO_ADDR;
                    end
                end
                ST_VEC_LO: begin
                    state_q    <= ST_VEC_HI;
                    vec_addr_o <= VEC_HI_ADDR;
                    pc_o[7:0]  <= vec_data_i; // [R5]
                end
                ST_VEC_HI: begin
                    state_q    <= ST_LOAD;
                    vec_rd_o   <= 1'b0;
                    pc_o[15:8] <= vec_data_i; // [R5]
                end
                ST_LOAD: begin
                    state_q   <= ST_RUN;
                    cpu_rst_o <= 1'b0;
                    pc_load_o <= 1'b1;
                end
                ST_RUN: begin
                    pc_load_o <= 1'b0;
                end
                default: begin
                    state_q <= ST_STRETCH;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // apb slave
    // ------------------------------------------------------------
    // one wait state so that read data leaves a flip-flop
    assign apb_setup = psel_i && penable_i && !pready_o;
    assign apb_wr    = psel_i && penable_i && pready_o && pwrite_i;
    assign cfg_ok    = flash_prog_mode_i; // [R13]

    always_comb begin
        rdata_d = 32'h0000_0000;
        rerr_d  = 1'b0;
        case (paddr_i)
            ADDR_CTRL:   rdata_d[CTRL_W-1:0] = ctrl_q;
            ADDR_STATUS: rdata_d[ST_W-1:0] = status_q;
            ADDR_MASK:   rdata_d[ST_W-1:0] = mask_q;
            ADDR_PAGE:   rdata_d[8:0] = page_q;
            ADDR_CFG: begin
                if (cfg_ok) begin
                    rdata_d[CFG_W-1:0] = cfg_q;
                end else begin
                    rerr_d = 1'b1; // [R13]
                end
            end
            ADDR_INFO: begin
                rdata_d[INFO_RUN]  = state_q == ST_RUN;
                rdata_d[INFO_FRZ]  = freeze_o;
                rdata_d[INFO_PORT] = port_in_o;
            end
            default: rerr_d = 1'b1;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            pready_o  <= 1'b0;
            prdata_o  <= 32'h0000_0000;
            pslverr_o <= 1'b0;
        end else begin
            pready_o  <= apb_setup;
            prdata_o  <= (apb_setup && !pwrite_i) ? rdata_d : 32'h0000_0000;
            pslverr_o <= apb_setup && rerr_d;
        end
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    // control and page clear on every internal reset; ram itself lives
    // elsewhere and is never cleared here [R7]
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || cpu_rst_o) begin
            ctrl_q <= CTRL_RST; // [R6]
            page_q <= PAGE_RST; // [R6]
        end else if (apb_wr) begin
            if (paddr_i == ADDR_CTRL) begin
                ctrl_q <= pwdata_i[CTRL_W-1:0];
            end
            if (paddr_i == ADDR_PAGE) begin
                page_q <= pwdata_i[8:0];
            end
        end
    end

    // the option area keeps its value over internal resets
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg_q <= CFG_RST;
        end else if (apb_wr && paddr_i == ADDR_CFG && cfg_ok) begin
            cfg_q <= pwdata_i[CFG_W-1:0]; // [R13]
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            mask_q <= MASK_RST;
        end else if (apb_wr && paddr_i == ADDR_MASK) begin
            mask_q <= pwdata_i[ST_W-1:0];
        end
    end

    // ------------------------------------------------------------
    // cause status and interrupt
    // ------------------------------------------------------------
    always_comb begin
        st_set            = '0;
        st_set[ST_POR]    = !supply_ok_s;
        st_set[ST_PIN]    = pin_rst_q;
        st_set[ST_WDT]    = wdt_timeout_i;
        st_set[ST_SF]     = pf_trip_q;
        st_set[ST_AFAIL]  = afail_q;
        st_clr            = (apb_wr && paddr_i == ADDR_STATUS) ? pwdata_i[ST_W-1:0] : '0;
    end

    // a cause arriving with its clear stays set
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            status_q <= STATUS_RST;
            irq_o    <= 1'b0;
        end else begin
            status_q <= (status_q & ~st_clr) | st_set;
            irq_o    <= |(status_q & mask_q);
        end
    end

    // ------------------------------------------------------------
    // control, page and option outputs
    // ------------------------------------------------------------
    assign ram_page_o        = page_q[PAGE_W-1:0];
    assign page_flag_o       = page_q[PAGE_FLAG];
    assign clk_alt_sel_o     = ctrl_q[CTRL_CLK_ALT];
    assign periph_clk_en_o   = ctrl_q[CTRL_PCLK_EN];
    assign wdt_en_o          = ctrl_q[CTRL_WDT_EN];
    assign supply_fail_en_o  = ctrl_q[CTRL_SF_EN];
    assign osc_noise_guard_o = cfg_q[CFG_NOISE]; // [R12]

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            port_in_o     <= 1'b1;
            int_osc_sel_o <= 1'b0;
        end else begin
            port_in_o     <= port_mode ? pin_n_s : 1'b1; // [R11]
            int_osc_sel_o <= cfg_q[CFG_IOSC_A] | cfg_q[CFG_IOSC_B]; // [R14]
        end
    end

    // crystal output shows the system clock divided by four
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !int_osc_sel_o) begin
            xdiv_q <= 2'h0;
            xout_o <= 1'b0;
        end else if (xdiv_q == 2'(XOUT_DIV / 2 - 1)) begin
            xdiv_q <= 2'h0;
            xout_o <= !xout_o; // [R14]
        end else begin
            xdiv_q <= xdiv_q + 2'h1;
        end
    end

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence vec_lo_s;
        vec_rd_o && vec_addr_o == VEC_LO_ADDR && !$past(vec_rd_o);
    endsequence
    sequence vec_hi_load_s;
        vec_rd_o && vec_addr_o == VEC_HI_ADDR ##1 !vec_rd_o && cpu_rst_o ##1 pc_load_o && !cpu_rst_o;
    endsequence

    chk_merge_rst: assert property (src |=> cpu_rst_o) // [R1]
        else $error("reset source did not assert internal reset");
    chk_por_hold: assert property (!supply_ok_s |=> cpu_rst_o && state_q == ST_STRETCH) // [R2]
        else $error("low supply did not hold reset");
    chk_pin_filter: assert property (pin_low_x [*8] |=> pin_rst_q) // [R3]
        else $error("pin low for eight clocks gave no reset");
    chk_release_wait: assert property ($fell(cpu_rst_o) |-> $past(stab_done, 4)) // [R4]
        else $error("release before stabilisation done");
    chk_vec_order: assert property (vec_lo_s |=> vec_hi_load_s) // [R5]
        else $error("vector fetch sequence wrong");
    chk_pc_vector: assert property (pc_load_o |-> pc_o == {$past(vec_data_i, 2), $past(vec_data_i, 3)}) // [R5]
        else $error("pc not loaded from vector");
    chk_rst_init: assert property ($rose(cpu_rst_o) |=> ctrl_q == CTRL_RST && page_q == PAGE_RST) // [R6]
        else $error("reset did not clear control state");
    chk_fetch_fail: assert property (fetch_bad && cfg_q[CFG_AFAIL_EN] && state_q == ST_RUN
        |=> afail_q ##1 cpu_rst_o) // [R8]
        else $error("bad fetch did not reset");
    chk_sf_gate: assert property (!ctrl_q[CTRL_SF_EN] |=> !pf_trip_q) // [R9]
        else $error("supply-fail trip while disabled");
    chk_sf_action: assert property (pf_low_x [*5] |=> pf_trip_q ##1 (freeze_o || cpu_rst_o)) // [R10]
        else $error("supply low 100 ns gave no action");
    chk_cfg_lock: assert property (apb_setup && paddr_i == ADDR_CFG && !flash_prog_mode_i
        |=> pready_o && pslverr_o && prdata_o == 32'h0000_0000) // [R13]
        else $error("option area reachable outside program mode");
    chk_xout_div: assert property (int_osc_sel_o && $changed(xout_o) // [R14]
        |=> $stable(xout_o) ##1 ($changed(xout_o) || !$past(int_osc_sel_o)))
        else $error("crystal output not clock divided by four");

endmodule

// *** hdl/rpf_stretch.sv ***
`timescale 1ns/100ps
module rpf_stretch #(
    parameter int LEN = 16
) (
    input  wire logic core_clk_i,
    input  wire logic rst_n_i,
    input  wire logic restart_i,
    output logic      done_o
);

    localparam int CW = $clog2(LEN + 1);

    logic [CW-1:0] cnt_q;

    if (LEN < 1) begin : g_len_chk
        $error("rpf_stretch: LEN must be at least 1");
    end

    // any restart starts the whole interval again
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || restart_i) begin
            cnt_q  <= '0;
            done_o <= 1'b0;
        end else if (!done_o) begin
            cnt_q  <= cnt_q + 1'b1;
            done_o <= (cnt_q == CW'(LEN - 1));
        end
    end

    chk_stretch_len: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(done_o) |-> cnt_q == CW'(LEN)) // [R4]
        else $error("stretch finished early or late");

endmodule

// *** hdl/rpf_sync2.sv ***
`timescale 1ns/100ps
module rpf_sync2 #(
    parameter int             W       = 1,
    parameter logic [W-1:0]   RST_VAL = '0
) (
    input  wire logic         core_clk_i,
    input  wire logic         rst_n_i,
    input  wire logic [W-1:0] async_i,
    output logic      [W-1:0] sync_o
);

    logic [W-1:0] meta_q;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

// *** verification/rpf_ext_model.sv ***
`timescale 1ns/100ps
module rpf_ext_model (
    // vector memory side
    input  wire logic        core_clk_i,
    input  wire logic        vec_rd_i,
    input  wire logic [15:0] vec_addr_i,
    input  wire logic [15:0] vector_i,
    output logic      [7:0]  vec_data_o,
    // external reset circuit
    output logic             reset_pin_n_o
);
    logic [7:0] idle_q;

    initial begin
        idle_q        = 8'h00;
        reset_pin_n_o = 1'b1;
    end

    // outside a read the byte flips each cycle, so a stale value never passes
    always @(posedge core_clk_i) begin
        idle_q <= ~idle_q;
    end

    // the byte answers the address standing in the same cycle
    assign vec_data_o = !vec_rd_i ? idle_q : (vec_addr_i[0] ? vector_i[15:8] : vector_i[7:0]);

    task automatic hold_pin(input int n);
        @(posedge core_clk_i);
        reset_pin_n_o <= 1'b0;
        repeat (n) @(posedge core_clk_i);
        reset_pin_n_o <= 1'b1;
    endtask
endmodule

// *** verification/rpf_reset_ctrl_bench.sv ***
`timescale 1ns/100ps
`define CHK(n, e, g) begin check_count++; if ((g) !== (e)) begin fails++; $display("unexpected %s exp %h got %h", n, e, g); end end
`define WAIT(s, v) begin for (n = 0; n < 300 && s !== v; n++) @(posedge clk); if (n == 300) begin fails++; end_of_test(); end end
module rpf_reset_ctrl_bench;
    import rpf_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam int STAB = 16;
    logic        clk, rst_n, psel, penable, pwrite, pready, pslverr, irq, pin_n, sup_ok, sup_low, flash;
    logic        port_in, xout, wdt, fv, vrd, pcl, crst, frz, pflag, calt, pclk, wen, sfen, ong, iosc;
    logic [7:0]  paddr, vdata, page;
    logic [15:0] fa, vaddr, pc, vec;
    logic [31:0] pwdata, prdata, rnd, r;
    logic        e;
    int          fails, check_count, n, i;

    rpf_reset_ctrl #(.STAB_CYCLES(STAB)) u_rpf_reset_ctrl (
        .core_clk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .irq_o(irq), .reset_pin_n_i(pin_n), .supply_ok_i(sup_ok), .supply_low_i(sup_low),
        .flash_prog_mode_i(flash), .port_in_o(port_in), .xout_o(xout), .wdt_timeout_i(wdt),
        .fetch_valid_i(fv), .fetch_addr_i(fa), .vec_rd_o(vrd), .vec_addr_o(vaddr), .vec_data_i(vdata),
        .pc_o(pc), .pc_load_o(pcl), .cpu_rst_o(crst), .freeze_o(frz), .ram_page_o(page),
        .page_flag_o(pflag), .clk_alt_sel_o(calt), .periph_clk_en_o(pclk), .wdt_en_o(wen),
        .supply_fail_en_o(sfen), .osc_noise_guard_o(ong), .int_osc_sel_o(iosc));
    rpf_ext_model u_rpf_ext_model (.core_clk_i(clk), .vec_rd_i(vrd), .vec_addr_i(vaddr), .vector_i(vec),
        .vec_data_o(vdata), .reset_pin_n_o(pin_n));

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        `WAIT(pready, 1'b1)
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] x, input string s);
        apb(1'b0, a, 32'h0);
        `CHK(s, x, r)
    endtask

    task automatic end_of_test;
        $display("checks %0d mismatches %0d", check_count, fails);
        if (fails == 0 && check_count > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // sequence
    // ------------------------------------------------------------
    initial begin
        {rst_n, psel, penable, pwrite, sup_ok, sup_low, flash, wdt, fv} = '0;
        {paddr, pwdata, fa} = '0;
        rnd = lfsr(32'h7dde);
        vec = rnd[15:0];
        fails = 0;
        check_count = 0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        repeat (30) @(posedge clk);
        `CHK("held", 1'b1, crst)
        sup_ok <= 1'b1;
        `WAIT(crst, 1'b0)
        `CHK("stretch", 1'b1, n >= STAB + 4)
        `CHK("pc", vec, pc)
        `CHK("pc_load", 1'b1, pcl)
        rd(ADDR_CTRL, 32'h0, "ctrl");
        rd(ADDR_STATUS, 32'h1, "status");
        rd(ADDR_PAGE, 32'h0, "page");
        rd(ADDR_INFO, 32'h5, "info");
        apb(1'b0, ADDR_CFG, 32'h0);
        `CHK("cfg_refused", 1'b1, e)
        apb(1'b0, 8'h18, 32'h0);
        `CHK("unmapped", 1'b1, e)
        for (i = 0; i < 4; i++) begin
            rnd = lfsr(rnd);
            apb(1'b1, ADDR_PAGE, {23'h0, rnd[8:0]});
            rd(ADDR_PAGE, {23'h0, rnd[8:0]}, "page_rw");
            apb(1'b1, ADDR_CTRL, {27'h0, 3'b111, rnd[1:0]});
            rd(ADDR_CTRL, {27'h0, 3'b111, rnd[1:0]}, "ctrl_rw");
        end
        `CHK("page_o", rnd[7:0], page)
        `CHK("ctl_on", 3'b111, {calt, pclk, wen})
        apb(1'b1, ADDR_STATUS, 32'h1f);
        wdt <= 1'b1;
        @(posedge clk);
        wdt <= 1'b0;
        `WAIT(crst, 1'b1)
        `WAIT(crst, 1'b0)
        `CHK("ctl_outs", 5'h0, {calt, pclk, wen, sfen, pflag})
        rd(ADDR_PAGE, 32'h0, "page_clr");
        rd(ADDR_STATUS, 32'h4, "wdt_src");
        `CHK("irq_masked", 1'b0, irq)
        apb(1'b1, ADDR_MASK, 32'h4);
        repeat (2) @(posedge clk);
        `CHK("irq_on", 1'b1, irq)
        apb(1'b1, ADDR_STATUS, 32'h4);
        repeat (2) @(posedge clk);
        `CHK("irq_off", 1'b0, irq)
        u_rpf_ext_model.hold_pin(5);
        repeat (20) @(posedge clk);
        `CHK("short_pin", 1'b0, crst)
        u_rpf_ext_model.hold_pin(10);
        `WAIT(crst, 1'b1)
        `WAIT(crst, 1'b0)
        apb(1'b1, ADDR_CTRL, 32'h3);
        sup_low <= 1'b1;
        `WAIT(frz, 1'b1)
        `CHK("frz_no_rst", 1'b0, crst)
        sup_low <= 1'b0;
        `WAIT(frz, 1'b0)
        apb(1'b1, ADDR_CTRL, 32'h1);
        sup_low <= 1'b1;
        `WAIT(crst, 1'b1)
        sup_low <= 1'b0;
        `WAIT(crst, 1'b0)
        sup_low <= 1'b1;
        repeat (20) @(posedge clk);
        `CHK("sf_off", 1'b0, crst)
        sup_low <= 1'b0;
        fv <= 1'b1;
        fa <= {2'b11, rnd[13:0]};
        repeat (6) @(posedge clk);
        `CHK("good_fetch", 1'b0, crst)
        fa <= {7'h0, rnd[8:0]};
        `WAIT(crst, 1'b1)
        fv <= 1'b0;
        `WAIT(crst, 1'b0)
        flash <= 1'b1;
        rd(ADDR_CFG, 32'h24, "cfg");
        apb(1'b1, ADDR_CFG, 32'h27);
        fork
            u_rpf_ext_model.hold_pin(10);
            begin
                repeat (6) @(posedge clk);
                `CHK("port_in_low", 1'b0, port_in)
            end
        join
        repeat (10) @(posedge clk);
        `CHK("pin_port", 1'b0, crst)
        apb(1'b1, ADDR_CFG, 32'h2c);
        repeat (3) @(posedge clk);
        `CHK("iosc", 1'b1, iosc)
        `CHK("noise_on", 1'b1, ong)
        n = 0;
        for (i = 0; i < 8; i++) begin
            e = xout;
            @(posedge clk);
            n += (xout !== e);
        end
        `CHK("xout_div", 4, n)
        apb(1'b1, ADDR_CFG, 32'h30);
        repeat (3) @(posedge clk);
        `CHK("iosc_b", 2'b01, {ong, iosc})
        apb(1'b1, ADDR_CFG, 32'h20);
        repeat (3) @(posedge clk);
        `CHK("noise_off", 2'b00, {ong, iosc})
        end_of_test();
    end
endmodule
